/* src/socket_diag_regs.svh */
`ifndef SOCKET_DIAG_REGS_SVH
`define SOCKET_DIAG_REGS_SVH
// Notes on behaviour
// - global send busy blocks sends elsewhere
// - receive pending until receive or read timeout empties buffer
// - payload at most 1536 bytes, 720 small
// - channel register names the waiting telegram
// - connection change flag, host fetches event
// - physical link flag follows link detect
// - eight per-channel flags, five defined bits
// - rx error flag is OR of bits 0-15
// - tx error flag is OR of bits 16-31
// - channel send active blocks send/connect/disconnect
// - port linked follows established TCP connection
// - failed command flag, cleared by success
// - diagnostic bits sticky until software clears
// - bit 0: telegram not read in time
// - bit 8: telegram longer than buffer
// - receiver error bits 10,12,13,14,15
// - transmitter error bits 23,28,29,30,31
// - bit 23: UDP send without link
// - 16 or 32 channels in total
// - station bus service takes one or two channels
// - read timeout defaults to 1000 ms
// - data and connection flags never together

`define OFS_GLOBAL      10'h000
`define OFS_CHAN_REG    10'h004
`define OFS_CMD         10'h008
`define OFS_SVC_PORTS   10'h00C
`define OFS_CHAN_AVAIL  10'h010
`define OFS_RX_LEN      10'h014
`define SEL_FLAGS       2'h1
`define SEL_DIAG        2'h2

`define GF_SEND_BUSY    0
`define GF_RX_PENDING   1
`define GF_CONN_EVENT   2
`define GF_PHYS_LINK    6

`define CF_RX_ERR       0
`define CF_SEND_ACTIVE  1
`define CF_TX_ERR       2
`define CF_PORT_LINKED  3
`define CF_CMD_FAILED   4

`define DB_READ_TIMEOUT 0
`define DB_LENGTH       8
`define DB_NO_STATION   23
`define DB_RX_MAILBOX   14
`define DB_RX_CHANNEL   15
`define DB_NO_CONN      30
`define DB_PROGRAM      31
`define RX_USED_MASK    16'hF501
`define TX_USED_MASK    16'hF080

`define SVC_PORTS_RESET 32'h0000_0000
`define SVC_DEFAULT_PORT 16'h13BA
`define MAX_BYTES_LARGE 1536
`define MAX_BYTES_SMALL 720
`define CHANNELS_LARGE  32
`define CHANNELS_SMALL  16
`define READ_TIMEOUT_MS 1000
`define CLOCK_HZ        100000000
`define READ_TIMEOUT_CYCLES (`READ_TIMEOUT_MS * (`CLOCK_HZ / 1000))
`endif

/* src/socket_diag_pkg.sv */
package socket_diag_pkg;
    typedef enum logic [2:0] {
        OP_OPEN       = 3'h1,
        OP_CLOSE      = 3'h2,
        OP_CONNECT    = 3'h3,
        OP_DISCONNECT = 3'h4,
        OP_SEND       = 3'h5,
        OP_RECEIVE    = 3'h6,
        OP_FETCH_CONN = 3'h7
    } cmd_op_t;
endpackage : socket_diag_pkg

/* src/socket_channel_diagnostics.sv */
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "socket_diag_regs.svh"
module socket_channel_diagnostics #(
    parameter int NUM_CHANNELS        = `CHANNELS_LARGE,
    parameter int MAX_BYTES           = `MAX_BYTES_LARGE,
    parameter int READ_TIMEOUT_CYCLES = `READ_TIMEOUT_CYCLES,
    localparam int CW = $clog2(NUM_CHANNELS)
) (
    input  wire logic                    clock_in,
    input  wire logic                    rst_in,
    input  wire logic                    ce_in,
    input  wire logic [9:0]              address_in,
    input  wire logic                    read_in,
    input  wire logic                    write_in,
    input  wire logic [31:0]             writedata_in,
    output logic      [31:0]             readdata_out,
    output logic                         waitrequest_out,
    output logic                         cmd_valid_out,
    output socket_diag_pkg::cmd_op_t     cmd_op_out,
    output logic      [CW-1:0]           cmd_chan_out,
    output logic      [15:0]             cmd_len_out,
    input  wire logic                    tx_done_in,
    input  wire logic                    rx_valid_in,
    input  wire logic [CW-1:0]           rx_chan_in,
    input  wire logic [15:0]             rx_len_in,
    output logic                         rx_ready_out,
    output logic                         rx_taken_out,
    output logic                         rx_drop_out,
    input  wire logic                    conn_valid_in,
    input  wire logic [CW-1:0]           conn_chan_in,
    output logic                         conn_ready_out,
    output logic                         conn_taken_out,
    input  wire logic                    rx_err_valid_in,
    input  wire logic                    tx_err_valid_in,
    input  wire logic [CW-1:0]           err_chan_in,
    input  wire logic [15:0]             err_bits_in,
    input  wire logic [NUM_CHANNELS-1:0] port_linked_in,
    input  wire logic                    phys_link_in
);
    initial begin
        if (NUM_CHANNELS != `CHANNELS_LARGE &&
            NUM_CHANNELS != `CHANNELS_SMALL) begin
            $error("channel count must be 16 or 32");
        end
        if (MAX_BYTES < 1 || MAX_BYTES > `MAX_BYTES_LARGE) begin
            $error("payload limit out of range");
        end
        if (READ_TIMEOUT_CYCLES < 1) begin
            $error("read timeout must be at least one cycle");
        end
    end

    localparam logic [15:0] MAX_LEN = 16'(MAX_BYTES);
    localparam logic [31:0] TMO_LAST = 32'(READ_TIMEOUT_CYCLES - 1);
    localparam logic [7:0]  NCH = 8'(NUM_CHANNELS);

    // bus slave: one wait cycle, answer at second edge
    logic        ack_r;
    logic        bus_go;
    logic        wr_go;
    logic [5:0]  reg_idx;
    logic        idx_ok;

    assign waitrequest_out = (read_in | write_in) & ~ack_r;
    assign bus_go  = ce_in & (read_in | write_in) & ack_r;
    assign wr_go   = bus_go & write_in;
    assign reg_idx = address_in[7:2];
    assign idx_ok  = {2'h0, reg_idx} < NCH;

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ack_r <= 1'b0;
        end else if (ce_in) begin
            ack_r <= (read_in | write_in) & ~ack_r;
        end
    end

    // state
    logic                    busy_r;
    logic [NUM_CHANNELS-1:0] active_r;
    logic [NUM_CHANNELS-1:0] failed_r;
    logic [NUM_CHANNELS-1:0] open_r;
    logic [CW-1:0]           tx_cur_r;
    logic                    rx_pend_r;
    logic                    conn_pend_r;
    logic [CW-1:0]           chan_reg_r;
    logic [15:0]             rx_len_r;
    logic [31:0]             tmo_r;
    logic                    phys_r;
    logic [31:0]             svc_ports_r;
    logic [31:0]             diag_r [NUM_CHANNELS];

    // command decode
    socket_diag_pkg::cmd_op_t op;
    logic        cmd_go;
    logic [7:0]  cchan;
    logic [CW-1:0] ci;
    logic        chan_ok;
    logic        udp;
    logic [15:0] clen;
    logic        cmd_ok;
    logic [31:0] cmd_bits;
    logic        do_send;
    logic        do_recv;
    logic        do_fetch;
    logic        do_open;
    logic        do_close;
    logic [7:0]  open_cnt;
    logic [7:0]  avail;
    logic [1:0]  svc_use;

    assign cmd_go  = wr_go & (address_in == `OFS_CMD);
    assign op      = socket_diag_pkg::cmd_op_t'(writedata_in[2:0]);
    assign udp     = writedata_in[3];
    assign cchan   = writedata_in[15:8];
    assign clen    = writedata_in[31:16];
    assign chan_ok = cchan < NCH;
    assign ci      = cchan[CW-1:0];
    assign open_cnt = 8'($countones(open_r));

    always_comb begin
        svc_use = 2'h0;
        if (svc_ports_r != `SVC_PORTS_RESET) begin
            svc_use = (svc_ports_r[15:0] == svc_ports_r[31:16]) ? 2'h1
                                                                 : 2'h2;
        end
        avail = NCH - {6'h0, svc_use};
    end

    always_comb begin
        cmd_ok   = 1'b0;
        cmd_bits = 32'h0000_0000;
        do_send  = 1'b0;
        do_recv  = 1'b0;
        do_fetch = 1'b0;
        do_open  = 1'b0;
        do_close = 1'b0;
        if (cmd_go && chan_ok) begin
            unique case (op)
                socket_diag_pkg::OP_OPEN: begin
                    if (!open_r[ci] && !busy_r && open_cnt < avail) begin
                        cmd_ok  = 1'b1;
                        do_open = 1'b1;
                    end
                end
                socket_diag_pkg::OP_CLOSE: begin
                    if (open_r[ci] && !active_r[ci]) begin
                        cmd_ok   = 1'b1;
                        do_close = 1'b1;
                    end
                end
                socket_diag_pkg::OP_CONNECT,
                socket_diag_pkg::OP_DISCONNECT: begin
                    cmd_ok = open_r[ci] && !active_r[ci] && !busy_r;
                end
                socket_diag_pkg::OP_SEND: begin
                    if (busy_r || active_r[ci] || !open_r[ci] ||
                        clen == 16'h0000 || clen > MAX_LEN) begin
                        cmd_bits[`DB_PROGRAM] = 1'b1;
                    end else if (udp && !phys_r) begin
                        cmd_bits[`DB_NO_STATION] = 1'b1;
                    end else if (!udp && !port_linked_in[ci]) begin
                        cmd_bits[`DB_NO_CONN] = 1'b1;
                    end else begin
                        cmd_ok  = 1'b1;
                        do_send = 1'b1;
                    end
                end
                socket_diag_pkg::OP_RECEIVE: begin
                    if (!rx_pend_r) begin
                        cmd_bits[`DB_RX_MAILBOX] = 1'b1;
                    end else if (ci != chan_reg_r) begin
                        cmd_bits[`DB_RX_CHANNEL] = 1'b1;
                    end else begin
                        cmd_ok  = 1'b1;
                        do_recv = 1'b1;
                    end
                end
                socket_diag_pkg::OP_FETCH_CONN: begin
                    if (conn_pend_r && ci == chan_reg_r) begin
                        cmd_ok   = 1'b1;
                        do_fetch = 1'b1;
                    end
                end
                default: cmd_ok = 1'b0;
            endcase
        end
    end

    // stack handshakes; data has priority over connection events
    logic rx_acc;
    logic rx_long;
    logic conn_acc;
    logic tmo_hit;

    assign rx_ready_out   = ~rx_pend_r & ~conn_pend_r;
    assign conn_ready_out = ~rx_pend_r & ~conn_pend_r & ~rx_valid_in;
    assign rx_acc   = ce_in & rx_valid_in & rx_ready_out;
    assign rx_long  = rx_len_in > MAX_LEN;
    assign conn_acc = ce_in & conn_valid_in & conn_ready_out;
    assign tmo_hit  = rx_pend_r & ~do_recv & (tmo_r == TMO_LAST);

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rx_pend_r  <= 1'b0;
            rx_len_r   <= 16'h0000;
            tmo_r      <= 32'h0000_0000;
            chan_reg_r <= '0;
        end else if (ce_in) begin
            if (rx_acc && !rx_long) begin
                rx_pend_r  <= 1'b1;
                rx_len_r   <= rx_len_in;
                chan_reg_r <= rx_chan_in;
                tmo_r      <= 32'h0000_0000;
            end else if (do_recv || tmo_hit) begin
                rx_pend_r <= 1'b0;
            end else if (rx_pend_r) begin
                tmo_r <= tmo_r + 32'h0000_0001;
            end
            if (conn_acc) begin
                chan_reg_r <= conn_chan_in;
            end
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            conn_pend_r <= 1'b0;
        end else if (ce_in) begin
            if (conn_acc) begin
                conn_pend_r <= 1'b1;
            end else if (do_fetch) begin
                conn_pend_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            busy_r   <= 1'b0;
            active_r <= '0;
            tx_cur_r <= '0;
            open_r   <= '0;
            failed_r <= '0;
            phys_r   <= 1'b0;
        end else if (ce_in) begin
            phys_r <= phys_link_in;
            if (do_send) begin
                busy_r       <= 1'b1;
                active_r[ci] <= 1'b1;
                tx_cur_r     <= ci;
            end else if (tx_done_in && busy_r) begin
                busy_r             <= 1'b0;
                active_r[tx_cur_r] <= 1'b0;
            end
            if (do_open) begin
                open_r[ci] <= 1'b1;
            end else if (do_close) begin
                open_r[ci] <= 1'b0;
            end
            if (cmd_go && chan_ok) begin
                failed_r[ci] <= ~cmd_ok;
            end
        end
    end

    // stack-side strobes
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cmd_valid_out  <= 1'b0;
            cmd_op_out     <= socket_diag_pkg::OP_OPEN;
            cmd_chan_out   <= '0;
            cmd_len_out    <= 16'h0000;
            rx_taken_out   <= 1'b0;
            rx_drop_out    <= 1'b0;
            conn_taken_out <= 1'b0;
        end else if (ce_in) begin
            cmd_valid_out  <= cmd_ok;
            rx_taken_out   <= do_recv;
            rx_drop_out    <= tmo_hit | (rx_acc & rx_long);
            conn_taken_out <= do_fetch;
            if (cmd_ok) begin
                cmd_op_out   <= op;
                cmd_chan_out <= ci;
                cmd_len_out  <= clen;
            end
        end
    end

    // sticky diagnostic words; a set in the clearing cycle wins
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            for (int c = 0; c < NUM_CHANNELS; c++) begin
                diag_r[c] <= 32'h0000_0000;
            end
        end else if (ce_in) begin
            for (int c = 0; c < NUM_CHANNELS; c++) begin
                logic [31:0] clr;
                logic [31:0] set;
                clr = 32'h0000_0000;
                set = 32'h0000_0000;
                if (wr_go && address_in[9:8] == `SEL_DIAG &&
                    {2'h0, reg_idx} == 8'(c)) begin
                    clr = writedata_in;
                end
                if (cmd_go && chan_ok && ci == CW'(c)) begin
                    set = set | cmd_bits;
                end
                if (rx_err_valid_in && err_chan_in == CW'(c)) begin
                    set[15:0] = set[15:0] | (err_bits_in & `RX_USED_MASK);
                end
                if (tx_err_valid_in && err_chan_in == CW'(c)) begin
                    set[31:16] = set[31:16] | (err_bits_in & `TX_USED_MASK);
                end
                if (rx_acc && rx_long && rx_chan_in == CW'(c)) begin
                    set[`DB_LENGTH] = 1'b1;
                end
                if (tmo_hit && chan_reg_r == CW'(c)) begin
                    set[`DB_READ_TIMEOUT] = 1'b1;
                end
                diag_r[c] <= (diag_r[c] & ~clr) | set;
            end
        end
    end

    // read mux
    logic [31:0] rd_val;
    logic [7:0]  chan_flags;

    always_comb begin
        chan_flags = 8'h00;
        if (idx_ok) begin
            chan_flags[`CF_RX_ERR]      = |diag_r[reg_idx[CW-1:0]][15:0];
            chan_flags[`CF_SEND_ACTIVE] = active_r[reg_idx[CW-1:0]];
            chan_flags[`CF_TX_ERR]      = |diag_r[reg_idx[CW-1:0]][31:16];
            chan_flags[`CF_PORT_LINKED] = port_linked_in[reg_idx[CW-1:0]];
            chan_flags[`CF_CMD_FAILED]  = failed_r[reg_idx[CW-1:0]];
        end
        rd_val = 32'h0000_0000;
        if (address_in[9:8] == `SEL_FLAGS) begin
            rd_val[7:0] = chan_flags;
        end else if (address_in[9:8] == `SEL_DIAG) begin
            rd_val = idx_ok ? diag_r[reg_idx[CW-1:0]] : 32'h0000_0000;
        end else begin
            unique case (address_in)
                `OFS_GLOBAL: begin
                    rd_val[`GF_SEND_BUSY]  = busy_r;
                    rd_val[`GF_RX_PENDING] = rx_pend_r;
                    rd_val[`GF_CONN_EVENT] = conn_pend_r;
                    rd_val[`GF_PHYS_LINK]  = phys_r;
                end
                `OFS_CHAN_REG:   rd_val[CW-1:0] = chan_reg_r;
                `OFS_SVC_PORTS:  rd_val = svc_ports_r;
                `OFS_CHAN_AVAIL: rd_val = {16'h0000, open_cnt, avail};
                `OFS_RX_LEN:     rd_val[15:0] = rx_len_r;
                default:         rd_val = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            readdata_out <= 32'h0000_0000;
            svc_ports_r  <= `SVC_PORTS_RESET;
        end else if (ce_in) begin
            if (read_in && !ack_r) begin
                readdata_out <= rd_val;
            end
            if (wr_go && address_in == `OFS_SVC_PORTS) begin
                svc_ports_r <= writedata_in;
            end
        end
    end
endmodule : socket_channel_diagnostics

/* bench/socket_diag_assertions.sv */
`timescale 1ns/1ps
module socket_diag_assertions #(
    parameter int NUM_CHANNELS = 32,
    parameter int MAX_BYTES    = 1536,
    localparam int CW          = $clog2(NUM_CHANNELS)
) (
    input wire logic                clock_in,
    input wire logic                rst_in,
    input wire logic                ce_in,
    input wire logic [9:0]          address_in,
    input wire logic                read_in,
    input wire logic                write_in,
    input wire logic [31:0]         writedata_in,
    input wire logic                waitrequest_out,
    input wire logic                cmd_valid_out,
    input socket_diag_pkg::cmd_op_t cmd_op_out,
    input wire logic [CW-1:0]       cmd_chan_out,
    input wire logic [15:0]         cmd_len_out,
    input wire logic                rx_valid_in,
    input wire logic [15:0]         rx_len_in,
    input wire logic                rx_ready_out,
    input wire logic                rx_taken_out,
    input wire logic                rx_drop_out,
    input wire logic                conn_ready_out,
    input wire logic                conn_taken_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    logic cmd_acc;
    logic rx_acc;
    assign cmd_acc = write_in && !waitrequest_out && ce_in
                     && address_in == 10'h008;
    assign rx_acc = rx_valid_in && rx_ready_out && ce_in;

    a_one_wait: assert property ((read_in || write_in) && waitrequest_out
        && ce_in |=> !waitrequest_out)
        else $error("bus wait not one cycle");
    a_data_first: assert property (conn_ready_out |-> rx_ready_out
        && !rx_valid_in)
        else $error("connection offered beside data");
    a_long_drop: assert property (rx_acc && rx_len_in > MAX_BYTES
        |=> rx_drop_out && rx_ready_out)
        else $error("overlong telegram kept");
    a_short_pends: assert property (rx_acc && rx_len_in <= MAX_BYTES
        |=> !rx_ready_out && !rx_drop_out)
        else $error("telegram not pending");
    a_cmd_source: assert property (cmd_valid_out
        |-> $past(cmd_acc, 1) || $past(cmd_acc, 2))
        else $error("command without write");
    a_taken_source: assert property (rx_taken_out |->
        $past(cmd_acc && writedata_in[2:0] == 3'h6, 1) ||
        $past(cmd_acc && writedata_in[2:0] == 3'h6, 2))
        else $error("receive taken without command");
    a_fields_hold: assert property ($changed({cmd_op_out, cmd_chan_out,
        cmd_len_out}) |-> cmd_valid_out)
        else $error("command fields moved");
    a_ready_rise: assert property ($rose(rx_ready_out) |-> ##[0:1]
        (rx_taken_out || rx_drop_out || conn_taken_out))
        else $error("pending cleared without cause");
    c_drop: cover property (rx_drop_out);
    c_send: cover property (cmd_valid_out
        && cmd_op_out == socket_diag_pkg::OP_SEND);
    c_conn: cover property (conn_taken_out);
endmodule : socket_diag_assertions

bind socket_channel_diagnostics socket_diag_assertions #(
    .NUM_CHANNELS(NUM_CHANNELS), .MAX_BYTES(MAX_BYTES)) u_chk (
    .clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in),
    .address_in(address_in), .read_in(read_in), .write_in(write_in),
    .writedata_in(writedata_in), .waitrequest_out(waitrequest_out),
    .cmd_valid_out(cmd_valid_out), .cmd_op_out(cmd_op_out),
    .cmd_chan_out(cmd_chan_out), .cmd_len_out(cmd_len_out),
    .rx_valid_in(rx_valid_in), .rx_len_in(rx_len_in),
    .rx_ready_out(rx_ready_out), .rx_taken_out(rx_taken_out),
    .rx_drop_out(rx_drop_out), .conn_ready_out(conn_ready_out),
    .conn_taken_out(conn_taken_out));

/* bench/stack_model.sv */
`timescale 1ns/1ps
module stack_model #(
    parameter int CW       = 5,
    parameter int TX_DELAY = 30
) (
    input wire logic                clock_in,
    input wire logic                rst_in,
    input wire logic                cmd_valid_in,
    input socket_diag_pkg::cmd_op_t cmd_op_in,
    input wire logic                rx_ready_in,
    input wire logic                conn_ready_in,
    output logic                    tx_done_out,
    output logic                    rx_valid_out = 1'b0,
    output logic [CW-1:0]           rx_chan_out = '0,
    output logic [15:0]             rx_len_out = '0,
    output logic                    conn_valid_out = 1'b0,
    output logic [CW-1:0]           conn_chan_out = '0
);
    int cnt_r;
    // send buffer drains a while after the command arrives
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_r <= 0;
            tx_done_out <= 1'b0;
        end else begin
            tx_done_out <= (cnt_r == 1);
            if (cmd_valid_in && cmd_op_in == socket_diag_pkg::OP_SEND)
                cnt_r <= TX_DELAY;
            else if (cnt_r != 0)
                cnt_r <= cnt_r - 1;
        end
    end
    // hold the offer until ready, then scramble the released lines
    task automatic offer(input logic c, input int ch, input int len);
        int n;
        @(posedge clock_in);
        if (c) begin
            conn_valid_out <= 1'b1;
            conn_chan_out <= ch[CW-1:0];
        end else begin
            rx_valid_out <= 1'b1;
            rx_chan_out <= ch[CW-1:0];
            rx_len_out <= len[15:0];
        end
        n = 0;
        do begin
            @(posedge clock_in);
            n++;
        end while ((c ? conn_ready_in : rx_ready_in) !== 1'b1 && n < 200);
        conn_valid_out <= 1'b0;
        rx_valid_out <= 1'b0;
        conn_chan_out <= ~conn_chan_out;
        rx_chan_out <= ~rx_chan_out;
        rx_len_out <= ~rx_len_out;
    endtask : offer
endmodule : stack_model

/* bench/tb.sv */
`timescale 1ns/1ps
module tb;
    localparam int CW = 5;
    localparam int TO = 50;
    logic        clock_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1;
    logic        read_in = 1'b0, write_in = 1'b0, phys_link_in = 1'b0;
    logic        rx_err_valid_in = 1'b0, tx_err_valid_in = 1'b0;
    logic [9:0]  address_in = '0;
    logic [31:0] writedata_in = '0, port_linked_in = '0, readdata_out, q;
    logic [CW-1:0] err_chan_in = '0, rx_chan_in, conn_chan_in, cmd_chan_out;
    logic [15:0] err_bits_in = '0, rx_len_in, cmd_len_out;
    logic        waitrequest_out, cmd_valid_out, tx_done_in, rx_valid_in;
    logic        rx_ready_out, rx_taken_out, rx_drop_out, conn_valid_in;
    logic        conn_ready_out, conn_taken_out;
    socket_diag_pkg::cmd_op_t cmd_op_out;
    int          n_fail = 0, num_checks = 0, i, held;
    int          diag_m [32];
    int          pend_q [$];

    always #5 clock_in = ~clock_in;

    socket_channel_diagnostics #(.READ_TIMEOUT_CYCLES(TO)) dut (.*);
    stack_model #(.CW(CW)) peer (.clock_in(clock_in), .rst_in(rst_in),
        .cmd_valid_in(cmd_valid_out), .cmd_op_in(cmd_op_out),
        .rx_ready_in(rx_ready_out), .conn_ready_in(conn_ready_out),
        .tx_done_out(tx_done_in), .rx_valid_out(rx_valid_in),
        .rx_chan_out(rx_chan_in), .rx_len_out(rx_len_in),
        .conn_valid_out(conn_valid_in), .conn_chan_out(conn_chan_in));

    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic wr, input int a, input int d);
        int n;
        n = 0;
        read_in <= !wr;
        write_in <= wr;
        address_in <= a[9:0];
        writedata_in <= d;
        do begin
            @(posedge clock_in);
            n++;
        end while (waitrequest_out !== 1'b0 && n < 20);
        q = readdata_out;
        if (n >= 20) begin
            n_fail++;
            test_done();
        end
        read_in <= 1'b0;
        write_in <= 1'b0;
        @(posedge clock_in);
    endtask : bus

    task automatic rdchk(input int a, input logic [31:0] exp);
        bus(1'b0, a, 0);
        chk(q, exp);
    endtask : rdchk

    task automatic cmd(input int op, input int udp, input int ch, input int len);
        bus(1'b1, 8, {len[15:0], ch[7:0], 4'h0, udp[0], op[2:0]});
    endtask : cmd

    task automatic wait_glob(input int b, input logic v);
        int n;
        for (n = 0; n < 100; n++) begin
            bus(1'b0, 0, 0);
            if (q[b] === v) break;
        end
        if (n == 100) begin
            n_fail++;
            test_done();
        end
    endtask : wait_glob

    task automatic err(input logic tx, input int ch);
        err_chan_in <= ch[CW-1:0];
        err_bits_in <= 16'hFFFF;
        tx_err_valid_in <= tx;
        rx_err_valid_in <= !tx;
        @(posedge clock_in);
        tx_err_valid_in <= 1'b0;
        rx_err_valid_in <= 1'b0;
        @(posedge clock_in);
    endtask : err

    function automatic logic [31:0] fl(int ch, int act, int fail, int lnk);
        return {27'h0, fail[0], lnk[0], |diag_m[ch][31:16], act[0],
                |diag_m[ch][15:0]};
    endfunction : fl

    initial begin
        void'($urandom(11963));
        foreach (diag_m[k]) diag_m[k] = 0;
        repeat (12) @(posedge clock_in);
        rst_in <= 1'b0;
        @(posedge clock_in);
        rdchk('h000, 0);
        rdchk('h228, 0);
        rdchk('h3FC, 0);
        err(1'b1, 10);
        err(1'b0, 10);
        diag_m[10] = 32'hF080F501;
        rdchk('h228, diag_m[10]);
        rdchk('h128, fl(10, 0, 0, 0));
        bus(1'b1, 'h228, 'h0000FFFF);
        diag_m[10] &= 32'hFFFF0000;
        bus(1'b1, 'h228, 0);
        rdchk('h228, diag_m[10]);
        rdchk('h128, fl(10, 0, 0, 0));
        phys_link_in <= 1'b1;
        @(posedge clock_in);
        rdchk('h000, 'h40);
        cmd(1, 1, 3, 0);
        cmd(1, 1, 4, 0);
        cmd(5, 1, 3, 1536);
        rdchk('h000, 'h41);
        chk({11'h000, cmd_chan_out, cmd_len_out}, 32'h0003_0600);
        chk(32'(cmd_op_out), 32'h0000_0005);
        rdchk('h10C, fl(3, 1, 0, 0));
        cmd(5, 1, 4, 100);
        diag_m[4] |= 32'h80000000;
        rdchk('h110, fl(4, 0, 1, 0));
        rdchk('h210, diag_m[4]);
        wait_glob(0, 1'b0);
        rdchk('h10C, fl(3, 0, 0, 0));
        cmd(5, 1, 3, 1537);
        diag_m[3] |= 32'h80000000;
        rdchk('h20C, diag_m[3]);
        cmd(5, 1, 4, 1536);
        rdchk('h110, fl(4, 1, 0, 0));
        wait_glob(0, 1'b0);
        phys_link_in <= 1'b0;
        @(posedge clock_in);
        cmd(5, 1, 3, 8);
        diag_m[3] |= 32'h00800000;
        rdchk('h20C, diag_m[3]);
        wait_glob(0, 1'b0);
        peer.offer(1'b0, 5, 100);
        pend_q.push_back(5);
        wait_glob(1, 1'b1);
        rdchk('h004, pend_q[0]);
        held = q;
        rdchk('h014, 100);
        cmd(6, 0, 6, 0);
        diag_m[6] |= 32'h8000;
        rdchk('h218, diag_m[6]);
        cmd(6, 0, held, 0);
        void'(pend_q.pop_front());
        rdchk('h000, 0);
        cmd(6, 0, 5, 0);
        diag_m[5] |= 32'h4000;
        rdchk('h214, diag_m[5]);
        peer.offer(1'b0, 7, 2000);
        diag_m[7] |= 32'h100;
        rdchk('h21C, diag_m[7]);
        rdchk('h11C, fl(7, 0, 0, 0));
        peer.offer(1'b0, 8, 64);
        wait_glob(1, 1'b1);
        repeat (TO + 10) @(posedge clock_in);
        diag_m[8] |= 1;
        rdchk('h220, diag_m[8]);
        rdchk('h000, 0);
        peer.offer(1'b1, 9, 0);
        wait_glob(2, 1'b1);
        rdchk('h004, 9);
        rdchk('h000, 'h4);
        cmd(7, 0, 9, 0);
        rdchk('h000, 0);
        port_linked_in <= $urandom;
        @(posedge clock_in);
        for (i = 0; i < 3; i++)
            rdchk('h100 + 4 * i, fl(i, 0, 0, port_linked_in[i]));
        bus(1'b1, 'h00C, 'h13BA13BA);
        rdchk('h010, 'h21F);
        test_done();
    end

    initial begin
        repeat (20000) @(posedge clock_in);
        n_fail++;
        test_done();
    end
endmodule : tb
